// ===== src/sysint_map.vh
// Register map, field positions, reset values and timing counts
// Assumes inclusion by the system integration unit and its testbench only
`ifndef SYSINT_MAP_VH
`define SYSINT_MAP_VH

// Byte addresses on the register bus (FE01 and FE03 are not word aligned)
`define BREAK_WAKE_STATUS_ADDR 16'hFE00
`define RESET_CAUSE_STATUS_ADDR 16'hFE01
`define BREAK_FLAG_CONTROL_ADDR 16'hFE03
`define IRQ_PENDING_A_ADDR 16'hFE04
`define IRQ_PENDING_B_ADDR 16'hFE08
`define IRQ_PENDING_C_ADDR 16'hFE0C
`define LOW_POWER_CONFIG_ADDR 16'hFE10
`define CORE_STATE_ADDR 16'hFE14

// Field positions
`define BREAK_WAKE_FLAG_BIT 1
`define BREAK_CLEAR_ENABLE_BIT 7
`define RC_POWER_UP_BIT 7
`define RC_PIN_BIT 6
`define RC_WATCHDOG_BIT 5
`define RC_BAD_OPCODE_BIT 4
`define RC_BAD_FETCH_BIT 3
`define RC_FORCED_MONITOR_BIT 2
`define RC_BROWNOUT_BIT 1
`define CFG_WATCHDOG_DISABLE_BIT 0
`define CFG_OSC_IN_HALT_BIT 1
`define CFG_SHORT_RECOVERY_BIT 2

// Reset values
`define RESET_CAUSE_POR_VALUE 8'h80
`define BREAK_FLAG_CONTROL_RESET 8'h00
`define LOW_POWER_CONFIG_RESET 8'h00

// Stop recovery counter end values; each recovery lasts one oscillator cycle more
`define LONG_RECOVERY_CYCLES 12'hFFF
`define SHORT_RECOVERY_CYCLES 12'h01F

`endif

// ===== src/system_integration_unit.v
// System integration unit: software trap and break vectoring, pending
// request status, break flag protection, wait and stop sequencing with
// stop recovery timing, and reset cause capture, on an AXI4-Lite slave.
// Assumes the core reports instruction events as one-cycle pulses and
// that i_mclk is the oscillator clock; reset causes arrive as pulses.
//
// Design decision made here: the AXI4-Lite slave port.
`include "sysint_map.vh"

module system_integration_unit #(
   parameter IRQ_COUNT = 16
)(
   input wire i_mclk,
   input wire i_resetn,
   // AXI4-Lite slave
   input wire [15:0] i_awaddr,
   input wire i_awvalid,
   output reg o_awready,
   input wire [31:0] i_wdata,
   input wire [3:0] i_wstrb,
   input wire i_wvalid,
   output reg o_wready,
   output reg [1:0] o_bresp,
   output reg o_bvalid,
   input wire i_bready,
   input wire [15:0] i_araddr,
   input wire i_arvalid,
   output reg o_arready,
   output reg [31:0] o_rdata,
   output reg [1:0] o_rresp,
   output reg o_rvalid,
   input wire i_rready,
   // Core side events (one-cycle pulses), plus i_core_irq and i_irq_lines as levels
   input wire i_soft_trap_instruction,
   input wire i_wait_instruction,
   input wire i_stop_instruction,
   input wire i_break_request,
   input wire i_break_exit,
   input wire i_core_irq,
   input wire [IRQ_COUNT:1] i_irq_lines,
   // Reset cause pulses
   input wire i_power_up_reset,
   input wire i_pin_reset,
   input wire i_watchdog_reset,
   input wire i_bad_opcode_reset,
   input wire i_bad_fetch_reset,
   input wire i_forced_monitor_reset,
   input wire i_brownout_reset,
   // Two-step clear from peripherals: step one and step two pulses
   input wire i_flag_clear_step1,
   input wire i_flag_clear_step2,
   // Outputs to core and clock tree
   output reg o_trap_take,
   output reg o_stack_pc_adjust,
   output reg o_vector_soft_trap,
   output reg o_clear_mask,
   output reg o_stack_start,
   output reg o_cpu_clock_en,
   output reg o_periph_clock_en,
   output reg o_clock_generator_bus_output,
   output reg o_oscillator_clock_en,
   output reg o_watchdog_run,
   output reg o_flag_clear_allow,
   output reg o_reset_active
);

   // Low-power states
   localparam ST_RUN = 2'd0;
   localparam ST_WAIT = 2'd1;
   localparam ST_STOP = 2'd2;
   localparam ST_RECOVER = 2'd3;

   reg [1:0] state_q; // Sequencer state
   reg [11:0] rec_cnt_q; // Stop recovery counter
   reg [11:0] rec_limit_q; // Selected recovery length
   reg rec_by_irq_q; // Recovery was started by an interrupt
   reg in_break_q; // CPU in break state
   reg break_wake_flag_q; // Break ended wait
   reg break_clear_enable_q; // Break clearing allowed
   reg [7:0] reset_cause_q; // Reset cause flags
   reg [2:0] lp_cfg_q; // Watchdog disable, osc in halt, short recovery
   reg step1_q; // First step of a two-step clear seen
   reg [IRQ_COUNT:1] pend_q; // Registered pending lines
   wire any_reset;
   wire clear_ok;
   wire wr_go;
   wire rd_go;
   reg [15:0] awaddr_q;
   reg [31:0] wdata_q;
   reg aw_have_q;
   reg w_have_q;
   reg [31:0] rd_mux;

   // Any reset source overrides interrupts
   assign any_reset = i_power_up_reset | i_pin_reset | i_watchdog_reset |
                      i_bad_opcode_reset | i_bad_fetch_reset |
                      i_forced_monitor_reset | i_brownout_reset;
   // Clearing allowed outside break or with enable set
   assign clear_ok = ~in_break_q | break_clear_enable_q;
   assign wr_go = aw_have_q & w_have_q & ~o_bvalid;
   assign rd_go = i_arvalid & o_arready;

   // Live pending status sampled every cycle
   genvar g;
   generate
      for (g = 1; g <= IRQ_COUNT; g = g + 1)
      begin : g_pend
         always @(posedge i_mclk or negedge i_resetn)
         begin
            if (!i_resetn)
               pend_q[g] <= 1'b0;
            else
               pend_q[g] <= i_irq_lines[g];
         end
      end
   endgenerate

   // Write address and data capture, either order accepted
   always @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_awready <= 1'b1;
         o_wready <= 1'b1;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 16'h0000;
         wdata_q <= 32'h00000000;
         o_bvalid <= 1'b0;
         o_bresp <= 2'b00;
      end
      else
      begin
         if (i_awvalid && o_awready)
         begin
            awaddr_q <= i_awaddr;
            aw_have_q <= 1'b1;
            o_awready <= 1'b0;
         end
         if (i_wvalid && o_wready)
         begin
            // Only byte lane 0 carries register data
            wdata_q <= i_wstrb[0] ? i_wdata : 32'h00000000;
            w_have_q <= i_wstrb[0];
            o_wready <= 1'b0;
            if (!i_wstrb[0])
               w_have_q <= 1'b1;
         end
         if (wr_go)
         begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            o_bvalid <= 1'b1;
            // Unmapped addresses answer with a slave error
            case (awaddr_q)
               `BREAK_WAKE_STATUS_ADDR, `RESET_CAUSE_STATUS_ADDR,
               `BREAK_FLAG_CONTROL_ADDR, `IRQ_PENDING_A_ADDR,
               `IRQ_PENDING_B_ADDR, `IRQ_PENDING_C_ADDR,
               `LOW_POWER_CONFIG_ADDR, `CORE_STATE_ADDR:
                  o_bresp <= 2'b00;
               default:
                  o_bresp <= 2'b10;
            endcase
         end
         else if (o_bvalid && i_bready)
         begin
            o_bvalid <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
         end
      end
   end

   // Read data multiplexer
   always @*
   begin
      rd_mux = 32'h00000000;
      case (i_araddr)
         `BREAK_WAKE_STATUS_ADDR:
            rd_mux[`BREAK_WAKE_FLAG_BIT] = break_wake_flag_q;
         `RESET_CAUSE_STATUS_ADDR:
            rd_mux[7:0] = reset_cause_q;
         `BREAK_FLAG_CONTROL_ADDR:
            rd_mux[`BREAK_CLEAR_ENABLE_BIT] = break_clear_enable_q;
         `IRQ_PENDING_A_ADDR:
            rd_mux[7:2] = pend_q[6:1]; // Bits 1:0 read zero
         `IRQ_PENDING_B_ADDR:
            rd_mux[7:0] = pend_q[14:7];
         `IRQ_PENDING_C_ADDR:
            rd_mux[1:0] = pend_q[16:15]; // Bits 7:2 read zero
         `LOW_POWER_CONFIG_ADDR:
            rd_mux[2:0] = lp_cfg_q;
         `CORE_STATE_ADDR:
            rd_mux[2:0] = {in_break_q, state_q};
         default:
            rd_mux = 32'h00000000;
      endcase
   end

   // Read channel: one outstanding read
   always @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         o_arready <= 1'b1;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h00000000;
         o_rresp <= 2'b00;
      end
      else if (rd_go)
      begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b1;
         o_rdata <= rd_mux;
         case (i_araddr)
            `BREAK_WAKE_STATUS_ADDR, `RESET_CAUSE_STATUS_ADDR,
            `BREAK_FLAG_CONTROL_ADDR, `IRQ_PENDING_A_ADDR,
            `IRQ_PENDING_B_ADDR, `IRQ_PENDING_C_ADDR,
            `LOW_POWER_CONFIG_ADDR, `CORE_STATE_ADDR:
               o_rresp <= 2'b00;
            default:
               o_rresp <= 2'b10;
         endcase
      end
      else if (o_rvalid && i_rready)
      begin
         o_rvalid <= 1'b0;
         o_arready <= 1'b1;
      end
   end

   // Reset cause flags; a new cause wins over the read clear
   always @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
         reset_cause_q <= `RESET_CAUSE_POR_VALUE;
      else if (i_power_up_reset)
         reset_cause_q <= `RESET_CAUSE_POR_VALUE;
      else
      begin
         if (rd_go && i_araddr == `RESET_CAUSE_STATUS_ADDR)
            reset_cause_q <= 8'h00;
         // Other causes accumulate
         if (i_pin_reset)
            reset_cause_q[`RC_PIN_BIT] <= 1'b1;
         if (i_watchdog_reset)
            reset_cause_q[`RC_WATCHDOG_BIT] <= 1'b1;
         if (i_bad_opcode_reset)
            reset_cause_q[`RC_BAD_OPCODE_BIT] <= 1'b1;
         if (i_bad_fetch_reset)
            reset_cause_q[`RC_BAD_FETCH_BIT] <= 1'b1;
         if (i_forced_monitor_reset)
            reset_cause_q[`RC_FORCED_MONITOR_BIT] <= 1'b1;
         if (i_brownout_reset)
            reset_cause_q[`RC_BROWNOUT_BIT] <= 1'b1;
      end
   end

   // Software registers: flag control, config, break wake flag
   always @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         break_clear_enable_q <= 1'b0;
         lp_cfg_q <= 3'b000;
         break_wake_flag_q <= 1'b0;
      end
      else
      begin
         if (wr_go && awaddr_q == `BREAK_FLAG_CONTROL_ADDR)
            break_clear_enable_q <= wdata_q[`BREAK_CLEAR_ENABLE_BIT];
         if (wr_go && awaddr_q == `LOW_POWER_CONFIG_ADDR)
            lp_cfg_q <= wdata_q[2:0];
         // Write zero clears; hardware set wins
         if (wr_go && awaddr_q == `BREAK_WAKE_STATUS_ADDR &&
             !wdata_q[`BREAK_WAKE_FLAG_BIT])
            break_wake_flag_q <= 1'b0;
         if (i_break_request && state_q == ST_WAIT)
            break_wake_flag_q <= 1'b1;
      end
   end

   // Break state and two-step clear protection
   always @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         in_break_q <= 1'b0;
         step1_q <= 1'b0;
         o_flag_clear_allow <= 1'b0;
      end
      else
      begin
         if (i_break_request)
            in_break_q <= 1'b1;
         else if (i_break_exit)
            in_break_q <= 1'b0;
         // Second step clears only when not protected
         o_flag_clear_allow <= i_flag_clear_step2 & step1_q & clear_ok;
         if (i_flag_clear_step2 && clear_ok)
            step1_q <= 1'b0; // Cleared flag stays cleared
         if (i_flag_clear_step1)
            step1_q <= 1'b1;
      end
   end

   // Trap, break vectoring and low-power sequencer
   always @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         state_q <= ST_RUN;
         rec_cnt_q <= 12'h000;
         rec_limit_q <= `LONG_RECOVERY_CYCLES;
         rec_by_irq_q <= 1'b0;
         o_trap_take <= 1'b0;
         o_stack_pc_adjust <= 1'b0;
         o_vector_soft_trap <= 1'b0;
         o_clear_mask <= 1'b0;
         o_stack_start <= 1'b0;
         o_cpu_clock_en <= 1'b1;
         o_periph_clock_en <= 1'b1;
         o_clock_generator_bus_output <= 1'b1;
         o_oscillator_clock_en <= 1'b1;
         o_watchdog_run <= 1'b1;
         o_reset_active <= 1'b0;
      end
      else
      begin
         o_reset_active <= any_reset;
         // Trap ignores the mask; stacks PC unchanged
         o_trap_take <= (i_soft_trap_instruction | i_break_request) &
                        ~any_reset;
         o_stack_pc_adjust <= i_core_irq & ~i_soft_trap_instruction;
         o_vector_soft_trap <= i_break_request & ~any_reset;
         o_clear_mask <= 1'b0;
         o_stack_start <= 1'b0;
         case (state_q)
            ST_RUN:
            begin
               o_watchdog_run <= 1'b1;
               if (i_wait_instruction)
               begin
                  state_q <= ST_WAIT;
                  o_cpu_clock_en <= 1'b0;
                  o_clear_mask <= 1'b1;
                  o_watchdog_run <= ~lp_cfg_q[`CFG_WATCHDOG_DISABLE_BIT];
               end
               else if (i_stop_instruction)
               begin
                  state_q <= ST_STOP;
                  rec_cnt_q <= 12'h000;
                  o_clear_mask <= 1'b1;
                  o_cpu_clock_en <= 1'b0;
                  o_periph_clock_en <= 1'b0;
                  o_watchdog_run <= 1'b0;
                  o_clock_generator_bus_output <=
                     lp_cfg_q[`CFG_OSC_IN_HALT_BIT];
                  o_oscillator_clock_en <= lp_cfg_q[`CFG_OSC_IN_HALT_BIT];
               end
            end
            ST_WAIT:
            begin
               // Watchdog keeps counting unless disabled
               if (any_reset)
               begin
                  state_q <= ST_RUN; // Reset first
                  o_cpu_clock_en <= 1'b1;
               end
               else if (i_core_irq || i_break_request)
               begin
                  state_q <= ST_RUN;
                  o_cpu_clock_en <= 1'b1;
                  o_stack_start <= 1'b1; // Next cycle
               end
            end
            ST_STOP:
            begin
               rec_cnt_q <= 12'h000; // Held in reset
               if (any_reset || i_core_irq)
               begin
                  state_q <= ST_RECOVER;
                  o_clock_generator_bus_output <= 1'b1;
                  o_oscillator_clock_en <= 1'b1;
                  rec_by_irq_q <= ~any_reset;
                  // Reset forces long recovery
                  if (!any_reset && lp_cfg_q[`CFG_SHORT_RECOVERY_BIT])
                     rec_limit_q <= `SHORT_RECOVERY_CYCLES;
                  else
                     rec_limit_q <= `LONG_RECOVERY_CYCLES;
               end
            end
            ST_RECOVER:
            begin
               // Counter times recovery
               if (any_reset)
                  rec_by_irq_q <= 1'b0;
               if (rec_cnt_q == rec_limit_q)
               begin
                  state_q <= ST_RUN;
                  rec_cnt_q <= 12'h000;
                  o_cpu_clock_en <= 1'b1;
                  o_periph_clock_en <= 1'b1;
                  o_watchdog_run <= 1'b1;
                  o_stack_start <= rec_by_irq_q;
               end
               else
                  rec_cnt_q <= rec_cnt_q + 12'h001;
            end
            default:
               state_q <= ST_RUN;
         endcase
      end
   end

endmodule

// ===== sim/sysint_chk.sv
// Port-level checker for the system integration unit
// Assumes one clock domain, async active low reset, pulse-style events
module sysint_chk (
   input wire i_mclk,
   input wire i_resetn,
   input wire i_soft_trap_instruction,
   input wire i_wait_instruction,
   input wire i_stop_instruction,
   input wire i_break_request,
   input wire i_core_irq,
   input wire i_pin_reset,
   input wire i_power_up_reset,
   input wire i_watchdog_reset,
   input wire i_bad_opcode_reset,
   input wire i_bad_fetch_reset,
   input wire i_forced_monitor_reset,
   input wire i_brownout_reset,
   input wire o_trap_take,
   input wire o_stack_pc_adjust,
   input wire o_vector_soft_trap,
   input wire o_clear_mask,
   input wire o_stack_start,
   input wire o_cpu_clock_en,
   input wire o_periph_clock_en,
   input wire o_reset_active
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);
   // Reset pulse in this cycle; it overrides trap and break events
   wire rst_in = i_pin_reset | i_power_up_reset | i_watchdog_reset |
      i_bad_opcode_reset | i_bad_fetch_reset | i_forced_monitor_reset |
      i_brownout_reset;
   // Low-power wait: core stopped, peripherals clocked
   wire in_wait = !o_cpu_clock_en && o_periph_clock_en;

   a_trap_taken: assert property (i_soft_trap_instruction && !rst_in
      |=> o_trap_take) else $error("trap not taken");
   a_trap_pc: assert property (i_soft_trap_instruction && !rst_in
      |=> !o_stack_pc_adjust) else $error("trap stacks adjusted pc");
   a_reset_first: assert property (i_soft_trap_instruction && rst_in
      |=> !o_trap_take && o_reset_active) else $error("trap beat reset");
   a_break_vector: assert property (i_break_request && !rst_in
      |=> o_vector_soft_trap && o_trap_take) else $error("no break vector");
   a_lowpow_mask: assert property ((i_wait_instruction
      || i_stop_instruction) && o_cpu_clock_en && !rst_in
      |=> o_clear_mask && !o_cpu_clock_en) else $error("mask not cleared");
   a_wait_periph: assert property (i_wait_instruction && o_cpu_clock_en
      && !rst_in |=> o_periph_clock_en [*2]) else $error("periph halted");
   a_wait_wake: assert property (in_wait && i_core_irq && !rst_in
      |=> o_stack_start && o_cpu_clock_en) else $error("late wait wake");
   a_stop_gate: assert property (i_stop_instruction && o_cpu_clock_en
      && !rst_in |=> !o_periph_clock_en && !o_cpu_clock_en)
      else $error("stop left clocks on");
   a_stop_hold: assert property (i_stop_instruction && o_cpu_clock_en
      && !rst_in |=> !o_stack_start [*8]) else $error("early stacking");

   c_wait_wake: cover property (in_wait && i_core_irq);
   c_trap_reset: cover property (i_soft_trap_instruction && rst_in);
   c_stack: cover property (o_stack_start);
endmodule

bind system_integration_unit sysint_chk sysint_chk_i (
   .i_mclk, .i_resetn, .i_soft_trap_instruction, .i_wait_instruction,
   .i_stop_instruction, .i_break_request, .i_core_irq, .i_pin_reset,
   .i_watchdog_reset, .i_bad_opcode_reset, .i_bad_fetch_reset,
   .i_forced_monitor_reset, .i_brownout_reset,
   .i_power_up_reset, .o_trap_take, .o_stack_pc_adjust, .o_vector_soft_trap,
   .o_clear_mask, .o_stack_start, .o_cpu_clock_en, .o_periph_clock_en,
   .o_reset_active
);

// ===== sim/core_model.sv
// Model of the core and peripherals: event pulses, reset causes, requests
// Assumes its tasks are entered right after a rising clock edge
module core_model (
   input wire i_mclk,
   output logic [6:0] o_ev,
   output logic [6:0] o_rc,
   output logic o_core_irq,
   output logic [16:1] o_lines
);
   timeunit 1ns;
   timeprecision 1ps;
   // Quiet until the first command
   initial
   begin
      o_ev = 7'h00;
      o_rc = 7'h00;
      o_core_irq = 1'b0;
      o_lines = 16'h0000;
   end
   // One-cycle pulses; returns at the edge that samples them
   task automatic pulse(input logic [6:0] ev, input logic [6:0] rc);
      @(posedge i_mclk);
      o_ev <= ev;
      o_rc <= rc;
      @(posedge i_mclk);
      o_ev <= 7'h00;
      o_rc <= 7'h00;
   endtask
   // Enabled request level towards the core
   task automatic irq(input logic v);
      @(posedge i_mclk);
      o_core_irq <= v;
   endtask
   // Pending request levels per source
   task automatic req(input logic [16:1] v);
      @(posedge i_mclk);
      o_lines <= v;
   endtask
endmodule

// ===== sim/system_integration_lowpower_status_tb.sv
// Self-checking bench for the system integration unit
// Assumes the core model drives all core events and request lines
`include "sysint_map.vh"
module system_integration_lowpower_status_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // Event order {trap, wait, stop, break, break exit, step1, step2}
   localparam logic [6:0] EV_TRAP = 7'h40, EV_WAIT = 7'h20, EV_STOP = 7'h10;
   localparam logic [6:0] EV_BRK = 7'h08, EV_BX = 7'h04, EV_S1 = 7'h02;
   localparam logic [6:0] EV_S2 = 7'h01, RC_PIN = 7'h20;
   logic i_mclk, i_resetn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
   logic [15:0] i_awaddr, i_araddr;
   logic [31:0] i_wdata, rd;
   logic [1:0] rr;
   logic [16:1] ln;
   wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
   wire [1:0] o_bresp, o_rresp;
   wire [31:0] o_rdata;
   wire o_trap_take, o_stack_pc_adjust, o_vector_soft_trap, o_clear_mask;
   wire o_stack_start, o_cpu_clock_en, o_periph_clock_en, o_watchdog_run;
   wire o_clock_generator_bus_output, o_oscillator_clock_en;
   wire o_flag_clear_allow, o_reset_active, core_irq;
   wire [6:0] ev, rc;
   wire [16:1] lines;
   int n_fail, checks, n, n_allow, a0, i;
   logic [21:0] rows [5]; // {first causes, second causes, expected}

   core_model core_model_i (.i_mclk, .o_ev(ev), .o_rc(rc),
      .o_core_irq(core_irq), .o_lines(lines));
   // Byte strobes tied: every register is one byte wide
   system_integration_unit system_integration_unit_i (
      .i_mclk, .i_resetn, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
      .i_wstrb(4'hF), .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
      .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
      .i_rready, .i_soft_trap_instruction(ev[6]), .i_wait_instruction(ev[5]),
      .i_stop_instruction(ev[4]), .i_break_request(ev[3]),
      .i_break_exit(ev[2]), .i_core_irq(core_irq), .i_irq_lines(lines),
      .i_power_up_reset(rc[6]), .i_pin_reset(rc[5]),
      .i_watchdog_reset(rc[4]), .i_bad_opcode_reset(rc[3]),
      .i_bad_fetch_reset(rc[2]), .i_forced_monitor_reset(rc[1]),
      .i_brownout_reset(rc[0]), .i_flag_clear_step1(ev[1]),
      .i_flag_clear_step2(ev[0]), .o_trap_take, .o_stack_pc_adjust,
      .o_vector_soft_trap, .o_clear_mask, .o_stack_start, .o_cpu_clock_en,
      .o_periph_clock_en, .o_clock_generator_bus_output,
      .o_oscillator_clock_en, .o_watchdog_run, .o_flag_clear_allow,
      .o_reset_active);

   // 200 MHz clock
   initial
   begin
      i_mclk = 1'b0;
      forever #2.5 i_mclk = ~i_mclk;
   end
   // Counts allow pulses; protection shows as a missing count
   always @(posedge i_mclk)
      if (o_flag_clear_allow === 1'b1)
         n_allow <= n_allow + 1;
   // Hang guard, well beyond the three stop recoveries
   initial
   begin
      #300000;
      n_fail++;
      finish_test();
   end

   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         $display("wrong value %s: expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask
   // Write: address and data offered together, bready held until bvalid
   task automatic axi_wr(input logic [15:0] a, input logic [7:0] d);
      int t;
      logic aw, w, b;
      @(posedge i_mclk);
      i_awaddr <= a;
      i_wdata <= {24'h000000, d};
      {i_awvalid, i_wvalid, i_bready} <= 3'h7;
      t = 0;
      b = 1'b0;
      while (!b && t < 50)
      begin
         @(negedge i_mclk);
         aw = i_awvalid && o_awready;
         w = i_wvalid && o_wready;
         b = o_bvalid;
         @(posedge i_mclk);
         t++;
         if (aw)
            i_awvalid <= 1'b0;
         if (w)
            i_wvalid <= 1'b0;
      end
      i_bready <= 1'b0;
      chk("bresp", 0, {30'h0, o_bresp});
      if (!b)
         n_fail++;
   endtask
   // Read: data and response sampled at the falling edge before the rvalid handshake edge
   task automatic axi_rd(input logic [15:0] a, output logic [31:0] d,
      output logic [1:0] r);
      int t;
      logic ar, rv;
      @(posedge i_mclk);
      i_araddr <= a;
      {i_arvalid, i_rready} <= 2'h3;
      t = 0;
      rv = 1'b0;
      while (!rv && t < 50)
      begin
         @(negedge i_mclk);
         ar = i_arvalid && o_arready;
         rv = o_rvalid;
         d = o_rdata;
         r = o_rresp;
         @(posedge i_mclk);
         t++;
         if (ar)
            i_arvalid <= 1'b0;
      end
      i_rready <= 1'b0;
      if (!rv)
         n_fail++;
   endtask
   task automatic rdc(input logic [15:0] a, input logic [7:0] e,
      input string nm);
      axi_rd(a, rd, rr);
      chk(nm, {24'h000000, e}, rd);
   endtask
   // Stop, idle, then leave by request or reset; n = cycles recovering
   task automatic stop_rec(input logic [7:0] cfg, input logic rst,
      output int d);
      logic st;
      axi_wr(`LOW_POWER_CONFIG_ADDR, cfg);
      core_model_i.pulse(EV_STOP, 7'h00);
      @(negedge i_mclk);
      chk("osc en", {31'h0, cfg[1]}, {31'h0, o_oscillator_clock_en});
      chk("gen out", {31'h0, cfg[1]}, {31'h0, o_clock_generator_bus_output});
      chk("periph", 32'h0, {31'h0, o_periph_clock_en});
      repeat (40) @(posedge i_mclk);
      if (rst)
         core_model_i.pulse(7'h00, RC_PIN);
      else
         core_model_i.irq(1'b1);
      d = 0;
      st = 1'b0;
      do
      begin
         @(negedge i_mclk);
         d++;
         st = st | o_stack_start;
      end while (!(rst ? o_cpu_clock_en : o_stack_start) && d < 5000);
      d = d - (rst ? 1 : 2);
      if (rst)
         chk("reset exit stack", 32'h0, {31'h0, st});
      core_model_i.irq(1'b0);
   endtask
   task automatic finish_test;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial
   begin
      rows[0] = {7'h20, 7'h00, 8'h40};
      rows[1] = {7'h10, 7'h00, 8'h20};
      rows[2] = {7'h08, 7'h04, 8'h18};
      rows[3] = {7'h02, 7'h01, 8'h06};
      rows[4] = {7'h20, 7'h40, 8'h80};
      {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
      i_awaddr = 16'h0000;
      i_araddr = 16'h0000;
      i_wdata = 32'h00000000;
      n_allow = 0;
      i_resetn = 1'b0;
      repeat (20) @(posedge i_mclk);
      i_resetn <= 1'b1;
      rdc(`RESET_CAUSE_STATUS_ADDR, 8'h80, "power-up cause");
      rdc(`BREAK_FLAG_CONTROL_ADDR, 8'h00, "clear enable");
      // Cause pairs: accumulation, and power-up wiping the rest
      for (i = 0; i < 5; i++)
      begin
         core_model_i.pulse(7'h00, rows[i][21:15]);
         core_model_i.pulse(7'h00, rows[i][14:8]);
         rdc(`RESET_CAUSE_STATUS_ADDR, rows[i][7:0], "cause");
         rdc(`RESET_CAUSE_STATUS_ADDR, 8'h00, "cause cleared");
      end
      core_model_i.pulse(EV_TRAP, 7'h00);
      @(negedge i_mclk);
      chk("trap", 32'h1, {31'h0, o_trap_take});
      chk("pc adjust", 32'h0, {31'h0, o_stack_pc_adjust});
      core_model_i.pulse(EV_TRAP, RC_PIN);
      @(negedge i_mclk);
      chk("trap in reset", 32'h0, {31'h0, o_trap_take});
      ln = 16'hA5C3;
      core_model_i.req(ln);
      axi_wr(`IRQ_PENDING_A_ADDR, 8'hFF);
      rdc(`IRQ_PENDING_A_ADDR, {ln[6:1], 2'h0}, "pending a");
      rdc(`IRQ_PENDING_B_ADDR, ln[14:7], "pending b");
      rdc(`IRQ_PENDING_C_ADDR, {6'h00, ln[16:15]}, "pending c");
      axi_rd(16'hFE40, rd, rr);
      chk("unmapped resp", 32'h2, {30'h0, rr});
      // Two-step clear straddling break entry while protected
      axi_wr(`BREAK_FLAG_CONTROL_ADDR, 8'h00);
      a0 = n_allow;
      core_model_i.pulse(EV_S1, 7'h00);
      core_model_i.pulse(EV_BRK, 7'h00);
      core_model_i.pulse(EV_S2, 7'h00);
      repeat (2) @(negedge i_mclk);
      chk("protected", a0, n_allow);
      core_model_i.pulse(EV_BX, 7'h00);
      core_model_i.pulse(EV_S2, 7'h00);
      repeat (2) @(negedge i_mclk);
      chk("after break", a0 + 1, n_allow);
      axi_wr(`BREAK_FLAG_CONTROL_ADDR, 8'h80);
      rdc(`BREAK_FLAG_CONTROL_ADDR, 8'h80, "clear enable rw");
      core_model_i.pulse(EV_BRK, 7'h00);
      core_model_i.pulse(EV_S1, 7'h00);
      core_model_i.pulse(EV_S2, 7'h00);
      repeat (2) @(negedge i_mclk);
      chk("clear in break", a0 + 2, n_allow);
      core_model_i.pulse(EV_BX, 7'h00);
      // Wait, then a break wakes it and leaves the wake flag
      axi_wr(`LOW_POWER_CONFIG_ADDR, 8'h00);
      core_model_i.pulse(EV_WAIT, 7'h00);
      @(negedge i_mclk);
      chk("wait cpu", 32'h0, {31'h0, o_cpu_clock_en});
      chk("wait periph", 32'h1, {31'h0, o_periph_clock_en});
      chk("watchdog", 32'h1, {31'h0, o_watchdog_run});
      core_model_i.pulse(EV_BRK, 7'h00);
      axi_rd(`BREAK_WAKE_STATUS_ADDR, rd, rr);
      chk("wake flag", 32'h2, rd & 32'h2);
      axi_wr(`BREAK_WAKE_STATUS_ADDR, 8'h00);
      axi_rd(`BREAK_WAKE_STATUS_ADDR, rd, rr);
      chk("wake cleared", 32'h0, rd & 32'h2);
      core_model_i.pulse(EV_BX, 7'h00);
      axi_wr(`LOW_POWER_CONFIG_ADDR, 8'h01);
      core_model_i.pulse(EV_WAIT, 7'h00);
      core_model_i.irq(1'b1);
      @(negedge i_mclk);
      chk("watchdog off", 32'h0, {31'h0, o_watchdog_run});
      @(negedge i_mclk);
      chk("wait stack", 32'h1, {31'h0, o_stack_start});
      core_model_i.irq(1'b0);
      stop_rec(8'h00, 1'b0, n);
      chk("long recovery", 32'd4096, n);
      stop_rec(8'h06, 1'b0, n);
      chk("short recovery", 32'd32, n);
      stop_rec(8'h04, 1'b1, n);
      chk("reset recovery", 32'd4096, n);
      finish_test();
   end
endmodule
